/* File: logic/exp_dram_pkg.sv */
// constants for the expansion dram control and refresh block
package exp_dram_pkg;
   localparam int ADDR_W = 20;
   localparam int ROW_W = 8;
   localparam int BLOCK_LSB = 17;
   localparam int BLOCK_W = 3;
   localparam int BANK_BIT = 16;
   localparam int COL_LSB = 8;
   localparam int NUM_BLOCKS = 3;
   localparam int CHAIN_LEN = 4;
   localparam int SYNC_W = 5;
   localparam int SYNC_ALE = 0;
   localparam int SYNC_SLOW = 1;
   localparam int SYNC_FAST = 2;
   localparam int SYNC_RD_N = 3;
   localparam int SYNC_WR_N = 4;
   localparam int REFRESH_ROWS = 256;
   localparam int REFRESH_WINDOW_NS = 2000000;
   localparam int CLK_PERIOD_NS = 20;
   // longest gap between two rows, rounded down
   localparam int ROW_INTERVAL_CYC = REFRESH_WINDOW_NS / REFRESH_ROWS / CLK_PERIOD_NS;
   localparam int INTERVAL_W = 9;
   localparam logic [INTERVAL_W-1:0] INTERVAL_LAST = INTERVAL_W'(ROW_INTERVAL_CYC - 1);
   localparam logic [INTERVAL_W-1:0] INTERVAL_ZERO = 9'h000;
   localparam logic [ROW_W-1:0] ROW_ZERO = 8'h00;
   localparam logic [ROW_W-1:0] ROW_ONE = 8'h01;
endpackage

/* File: logic/refresh_if.sv */
// refresh timer to sequencer link
`timescale 1ns/1ps
`default_nettype none
interface refresh_if;
   logic row_due;
   logic row_done;
   logic [exp_dram_pkg::ROW_W-1:0] row_addr;
   modport timer (output row_due, output row_addr, input row_done);
   modport ctrl (input row_due, input row_addr, output row_done);
endinterface
`default_nettype wire

/* File: logic/refresh_timer.sv */
// refresh interval timer and refresh row counter
`timescale 1ns/1ps
`default_nettype none
module refresh_timer (
   input wire logic core_clk,
   input wire logic resetn,
   refresh_if.timer rif
);
   logic [exp_dram_pkg::INTERVAL_W-1:0] interval_ff;
   logic [exp_dram_pkg::ROW_W-1:0] row_ff;

   // one row due per interval so all rows are covered inside the window
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         interval_ff <= exp_dram_pkg::INTERVAL_ZERO;
      end else if (interval_ff == exp_dram_pkg::INTERVAL_LAST) begin
         interval_ff <= exp_dram_pkg::INTERVAL_ZERO;
      end else begin
         interval_ff <= interval_ff + 9'h001;
      end
   end

   assign rif.row_due = (interval_ff == exp_dram_pkg::INTERVAL_LAST);

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         row_ff <= exp_dram_pkg::ROW_ZERO;
      end else if (rif.row_done) begin
         row_ff <= row_ff + exp_dram_pkg::ROW_ONE;
      end
   end

   assign rif.row_addr = row_ff;
endmodule // refresh_timer
`default_nettype wire

/* File: logic/expansion_dram_refresh_control.sv */
// dram timing, board decode, address mux and ras-only refresh sequencing
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - row and column strobes and mux run continuously, selected or not
// - row strobe follows request, fast-clock chain
// - column strobe when either column phase set
// - mux select equals cycle request directly
// - board enable and block decode low on hit
// - processor address unless refresh select high
// - write enable on writes, transceiver follows strobes
// - refresh every row within two milliseconds
// - refresh request cleared by and-term, slow clock
// - row strobe low in refresh once the first chain stage sets
// - refresh row advances per request transition
// - both bank row strobes low, no column strobe
// - each chip one bit, one 64K bank
// - three identical 128K blocks share control
module expansion_dram_refresh_control (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic ale,
   input wire logic slow_system_clock,
   input wire logic fast_system_clock,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [exp_dram_pkg::ADDR_W-1:0] cpu_addr,
   input wire logic [exp_dram_pkg::BLOCK_W-1:0] window_first_block,
   output logic board_en_n,
   output logic [exp_dram_pkg::NUM_BLOCKS-1:0] block_sel_n,
   output logic row_strobe_n,
   output logic bank0_row_strobe,
   output logic bank1_row_strobe,
   output logic col_strobe_n,
   output logic addr_mux_sel,
   output logic refresh_address_select,
   output logic [exp_dram_pkg::ROW_W-1:0] dram_addr,
   output logic dram_we_n,
   output logic xcvr_dir,
   output logic xcvr_en_n
);
   logic [exp_dram_pkg::SYNC_W-1:0] pin_raw;
   logic [exp_dram_pkg::SYNC_W-1:0] pin_s1_ff;
   logic [exp_dram_pkg::SYNC_W-1:0] pin_s2_ff;
   logic [exp_dram_pkg::SYNC_W-1:0] pin_d_ff;
   logic [exp_dram_pkg::ADDR_W-1:0] addr_s1_ff;
   logic [exp_dram_pkg::ADDR_W-1:0] addr_s2_ff;
   logic [exp_dram_pkg::BLOCK_W-1:0] win_s1_ff;
   logic [exp_dram_pkg::BLOCK_W-1:0] win_s2_ff;
   logic ale_rise;
   logic slow_tick;
   logic fast_tick;
   logic ale_seen_ff;
   logic cycle_request_ff;
   logic [exp_dram_pkg::CHAIN_LEN-1:0] chain_ff;
   logic column_phase_ff_a;
   logic column_phase_ff_b;
   logic refresh_request_ff;
   logic refresh_active_ff;
   logic chain_done;
   logic refresh_clear;
   logic [exp_dram_pkg::BLOCK_W-1:0] blk;
   logic [exp_dram_pkg::BLOCK_W-1:0] rel_blk;
   logic hit;
   logic bank;
   logic cpu_rd;
   logic cpu_wr;

   refresh_if rif ();

   refresh_timer u_refresh_timer (
      .core_clk(core_clk),
      .resetn(resetn),
      .rif(rif)
   );

   assign pin_raw = {wr_n, rd_n, fast_system_clock, slow_system_clock, ale};

   // every pin passes two flops; edges compare the second stage with a third, delayed flop
   genvar gi;
   generate
      for (gi = 0; gi < exp_dram_pkg::SYNC_W; gi++) begin : g_sync
         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               pin_s1_ff[gi] <= 1'b0;
               pin_s2_ff[gi] <= 1'b0;
               pin_d_ff[gi] <= 1'b0;
            end else begin
               pin_s1_ff[gi] <= pin_raw[gi];
               pin_s2_ff[gi] <= pin_s1_ff[gi];
               pin_d_ff[gi] <= pin_s2_ff[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         addr_s1_ff <= '0;
         addr_s2_ff <= '0;
         win_s1_ff <= '0;
         win_s2_ff <= '0;
      end else begin
         addr_s1_ff <= cpu_addr;
         addr_s2_ff <= addr_s1_ff;
         win_s1_ff <= window_first_block;
         win_s2_ff <= win_s1_ff;
      end
   end

   assign ale_rise = pin_s2_ff[exp_dram_pkg::SYNC_ALE] & ~pin_d_ff[exp_dram_pkg::SYNC_ALE];
   assign slow_tick = pin_s2_ff[exp_dram_pkg::SYNC_SLOW] & ~pin_d_ff[exp_dram_pkg::SYNC_SLOW];
   assign fast_tick = pin_s2_ff[exp_dram_pkg::SYNC_FAST] & ~pin_d_ff[exp_dram_pkg::SYNC_FAST];
   assign cpu_rd = ~pin_s2_ff[exp_dram_pkg::SYNC_RD_N];
   assign cpu_wr = ~pin_s2_ff[exp_dram_pkg::SYNC_WR_N];

   // window decode: three consecutive 128K blocks from the strapped first one
   assign blk = addr_s2_ff[exp_dram_pkg::BLOCK_LSB +: exp_dram_pkg::BLOCK_W];
   assign rel_blk = blk - win_s2_ff;
   assign hit = (blk >= win_s2_ff) && (rel_blk < exp_dram_pkg::BLOCK_W'(exp_dram_pkg::NUM_BLOCKS));
   assign bank = addr_s2_ff[exp_dram_pkg::BANK_BIT];

   // ale seen while a refresh runs is held, so no processor cycle is dropped
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ale_seen_ff <= 1'b0;
      end else if (ale_rise) begin
         ale_seen_ff <= 1'b1;
      end else if (slow_tick && !refresh_active_ff && !cycle_request_ff) begin
         ale_seen_ff <= 1'b0;
      end
   end

   assign chain_done = chain_ff[exp_dram_pkg::CHAIN_LEN-1];

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cycle_request_ff <= 1'b0;
      end else if (slow_tick) begin
         if (cycle_request_ff && chain_done) begin
            cycle_request_ff <= 1'b0;
         end else if (ale_seen_ff && !refresh_active_ff) begin
            cycle_request_ff <= 1'b1;
         end
      end
   end

   // a refresh starts only between processor cycles, on a slow edge
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         refresh_active_ff <= 1'b0;
      end else if (slow_tick) begin
         if (refresh_clear) begin
            refresh_active_ff <= 1'b0;
         end else if (refresh_request_ff && !cycle_request_ff && !ale_seen_ff) begin
            refresh_active_ff <= 1'b1;
         end
      end
   end

   assign refresh_clear = refresh_active_ff & chain_done;

   // a new due pulse in the clearing cycle is kept: set wins
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         refresh_request_ff <= 1'b0;
      end else if (rif.row_due) begin
         refresh_request_ff <= 1'b1;
      end else if (slow_tick && refresh_clear) begin
         refresh_request_ff <= 1'b0;
      end
   end

   assign rif.row_done = slow_tick & refresh_clear;

   // each chain stage is set by a fast edge once the stage before it is set
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         chain_ff <= '0;
      end else if (!cycle_request_ff && !refresh_active_ff) begin
         chain_ff <= '0;
      end else if (fast_tick) begin
         chain_ff <= {chain_ff[exp_dram_pkg::CHAIN_LEN-2:0], 1'b1};
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         column_phase_ff_a <= 1'b0;
         column_phase_ff_b <= 1'b0;
      end else if (!cycle_request_ff) begin
         column_phase_ff_a <= 1'b0;
         column_phase_ff_b <= 1'b0;
      end else begin
         if (fast_tick) begin
            column_phase_ff_a <= chain_ff[1];
         end
         if (slow_tick) begin
            column_phase_ff_b <= column_phase_ff_a;
         end
      end
   end

   // pin drivers; all registered so outputs never glitch on decode
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         row_strobe_n <= 1'b1;
         bank0_row_strobe <= 1'b1;
         bank1_row_strobe <= 1'b1;
         col_strobe_n <= 1'b1;
         addr_mux_sel <= 1'b0;
         refresh_address_select <= 1'b0;
      end else begin
         // the chain clears one cycle after its flag drops; gating with the flag keeps a stale
         // chain from putting a stray strobe on the array with whatever address is pending
         row_strobe_n <= ~(chain_ff[0] & (cycle_request_ff | refresh_active_ff));
         addr_mux_sel <= cycle_request_ff;
         refresh_address_select <= refresh_active_ff;
         col_strobe_n <= ~((column_phase_ff_a | column_phase_ff_b) & cycle_request_ff & ~refresh_active_ff);
         if (refresh_active_ff) begin
            bank0_row_strobe <= ~chain_ff[0];
            bank1_row_strobe <= ~chain_ff[0];
         end else begin
            bank0_row_strobe <= ~(chain_ff[0] & cycle_request_ff & hit & ~bank);
            bank1_row_strobe <= ~(chain_ff[0] & cycle_request_ff & hit & bank);
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         dram_addr <= exp_dram_pkg::ROW_ZERO;
      end else if (refresh_active_ff) begin
         dram_addr <= rif.row_addr;
      end else if (column_phase_ff_a | column_phase_ff_b) begin
         dram_addr <= addr_s2_ff[exp_dram_pkg::COL_LSB +: exp_dram_pkg::ROW_W];
      end else begin
         dram_addr <= addr_s2_ff[exp_dram_pkg::ROW_W-1:0];
      end
   end

   // one decode drives all three blocks alike
   generate
      for (gi = 0; gi < exp_dram_pkg::NUM_BLOCKS; gi++) begin : g_blk
         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               block_sel_n[gi] <= 1'b1;
            end else begin
               block_sel_n[gi] <= ~(cycle_request_ff && hit &&
                                    rel_blk == exp_dram_pkg::BLOCK_W'(gi));
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         board_en_n <= 1'b1;
         dram_we_n <= 1'b1;
         xcvr_dir <= 1'b0;
         xcvr_en_n <= 1'b1;
      end else begin
         board_en_n <= ~(cycle_request_ff & hit);
         dram_we_n <= ~(cycle_request_ff & hit & cpu_wr);
         xcvr_dir <= cpu_rd & ~cpu_wr;
         xcvr_en_n <= ~(cycle_request_ff & hit & (cpu_rd | cpu_wr));
      end
   end
endmodule // expansion_dram_refresh_control
`default_nettype wire

/* File: verif/exp_dram_properties.sv */
// port assertions for the dram control and refresh block
`timescale 1ns/1ps
`default_nettype none
module exp_dram_checker (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic board_en_n,
   input wire logic [exp_dram_pkg::NUM_BLOCKS-1:0] block_sel_n,
   input wire logic row_strobe_n,
   input wire logic bank0_row_strobe,
   input wire logic bank1_row_strobe,
   input wire logic col_strobe_n,
   input wire logic addr_mux_sel,
   input wire logic refresh_address_select,
   input wire logic dram_we_n,
   input wire logic xcvr_dir,
   input wire logic xcvr_en_n
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   logic [10:0] gap_ff;
   // a refresh may wait behind one processor cycle, so the bound has slack past the interval
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) gap_ff <= 11'h000;
      else if (refresh_address_select) gap_ff <= 11'h000;
      else gap_ff <= gap_ff + 11'h001;
   end
   sequence refresh_start;
      $rose(refresh_address_select);
   endsequence
   sequence all_rows_low;
      !row_strobe_n && !bank0_row_strobe && !bank1_row_strobe;
   endsequence
   refresh_no_col_a: assert property (refresh_address_select |-> col_strobe_n)
      else $error("column strobe during refresh");
   refresh_rows_a: assert property (refresh_start |-> ##[1:40] all_rows_low)
      else $error("refresh without row strobes");
   refresh_banks_a: assert property (refresh_address_select && !row_strobe_n |-> all_rows_low)
      else $error("bank strobe high in refresh");
   hit_one_block_a: assert property (!board_en_n |-> $onehot(~block_sel_n))
      else $error("block select not one-hot");
   miss_no_block_a: assert property (board_en_n |-> &block_sel_n)
      else $error("block select without enable");
   write_on_hit_a: assert property (!dram_we_n |-> !board_en_n && !xcvr_en_n && !xcvr_dir)
      else $error("write enable outside write hit");
   xcvr_on_hit_a: assert property (!xcvr_en_n |-> !board_en_n)
      else $error("transceiver on without enable");
   refresh_no_cpu_a: assert property (refresh_address_select |-> board_en_n && dram_we_n)
      else $error("processor access during refresh");
   col_after_row_a: assert property ($fell(col_strobe_n) |-> !row_strobe_n && addr_mux_sel)
      else $error("column strobe before row or mux");
   refresh_gap_a: assert property (gap_ff < 11'h258)
      else $error("refresh interval overrun");
endmodule // exp_dram_checker
bind expansion_dram_refresh_control exp_dram_checker chk (.core_clk, .resetn, .board_en_n, .block_sel_n,
   .row_strobe_n, .bank0_row_strobe, .bank1_row_strobe, .col_strobe_n, .addr_mux_sel, .refresh_address_select,
   .dram_we_n, .xcvr_dir, .xcvr_en_n);
`default_nettype wire

/* File: verif/host_clock_model.sv */
// free-running host system clock pins
`timescale 1ns/1ps
`default_nettype none
module host_clock_model #(
   parameter int FAST_HALF = 4,
   parameter int SLOW_HALF = 12
) (
   input wire logic core_clk,
   output logic slow_system_clock,
   output logic fast_system_clock
);
   int cnt = 0;
   initial begin
      slow_system_clock = 1'h0;
      fast_system_clock = 1'h0;
   end
   // pins move on the falling core edge, well clear of the sync flops' sampling
   always @(negedge core_clk) begin
      cnt <= cnt + 1;
      if (cnt % FAST_HALF == FAST_HALF - 1) fast_system_clock <= ~fast_system_clock;
      if (cnt % SLOW_HALF == SLOW_HALF - 1) slow_system_clock <= ~slow_system_clock;
   end
endmodule // host_clock_model
`default_nettype wire

/* File: verif/expansion_dram_refresh_control_tb.sv */
// self-checking bench for the dram control and refresh block
`timescale 1ns/1ps
`default_nettype none
module expansion_dram_refresh_control_tb;
   typedef struct packed {logic [2:0] s; logic [19:0] a; logic wr; logic hit; logic [2:0] sel;} row_t;
   logic core_clk, resetn, ale, rd_n, wr_n, slow_system_clock, fast_system_clock;
   logic [exp_dram_pkg::ADDR_W-1:0] cpu_addr;
   logic [exp_dram_pkg::BLOCK_W-1:0] window_first_block;
   logic board_en_n, row_strobe_n, bank0_row_strobe, bank1_row_strobe, col_strobe_n;
   logic addr_mux_sel, refresh_address_select, dram_we_n, xcvr_dir, xcvr_en_n;
   logic [exp_dram_pkg::NUM_BLOCKS-1:0] block_sel_n;
   logic [exp_dram_pkg::ROW_W-1:0] dram_addr, r0;
   int bad_count = 0, n_checks = 0, cyc = 0;
   row_t rows [7] = '{'{3'h1, 20'h20000, 1'h0, 1'h1, 3'h6}, '{3'h1, 20'h3ffff, 1'h1, 1'h1, 3'h6},
      '{3'h1, 20'h41234, 1'h1, 1'h1, 3'h5}, '{3'h1, 20'h7ffff, 1'h0, 1'h1, 3'h3},
      '{3'h1, 20'h1ffff, 1'h1, 1'h0, 3'h7}, '{3'h1, 20'h80000, 1'h0, 1'h0, 3'h7},
      '{3'h4, 20'h8a5c3, 1'h0, 1'h1, 3'h6}};
   host_clock_model clk_src (.core_clk, .slow_system_clock, .fast_system_clock);
   expansion_dram_refresh_control dut (.core_clk, .resetn, .ale, .slow_system_clock, .fast_system_clock, .rd_n,
      .wr_n, .cpu_addr, .window_first_block, .board_en_n, .block_sel_n, .row_strobe_n, .bank0_row_strobe,
      .bank1_row_strobe, .col_strobe_n, .addr_mux_sel, .refresh_address_select, .dram_addr, .dram_we_n,
      .xcvr_dir, .xcvr_en_n);
   task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic check_idle();
      check("idle", {board_en_n, block_sel_n, row_strobe_n, bank0_row_strobe, bank1_row_strobe, col_strobe_n,
         addr_mux_sel, refresh_address_select, dram_we_n, xcvr_dir, xcvr_en_n, dram_addr}, {13'h1fe5, 8'h00});
   endtask
   // one processor cycle; address, window and rd/wr levels held for the whole observation window, ale pulsed
   task automatic do_row(row_t r);
      logic [9:0] o;
      logic [7:0] ra, ca;
      // let an edge pass so strobes released by the previous call are not driven twice in one step
      @(negedge core_clk);
      o = 10'h1f0;
      window_first_block = r.s;
      cpu_addr = r.a;
      rd_n = r.wr;
      wr_n = !r.wr;
      ale = 1'h1;
      for (int i = 0; i < 200; i++) begin
         @(negedge core_clk);
         if (i == 4) ale = 1'h0;
         if (!board_en_n) o[9] = 1'h1;
         o[8:6] &= block_sel_n;
         if (!refresh_address_select) o[5:4] &= {bank1_row_strobe, bank0_row_strobe};
         if (!dram_we_n) o[3] = 1'h1;
         if (!xcvr_en_n) o[2] |= xcvr_dir;
         if (!row_strobe_n && !refresh_address_select && !o[1]) ra = dram_addr;
         if (!row_strobe_n && !refresh_address_select) o[1] = 1'h1;
         if (!col_strobe_n && !o[0]) ca = dram_addr;
         if (!col_strobe_n) o[0] = 1'h1;
      end
      rd_n = 1'h1;
      wr_n = 1'h1;
      check("cycle", 24'(o), 24'({r.hit, r.sel, r.hit ? {~r.a[16], r.a[16]} : 2'h3,
         r.hit & r.wr, r.hit & !r.wr, 2'h3}));
      if (r.hit) check("mux addr", 24'({ra, ca}), 24'({r.a[7:0], r.a[15:8]}));
      $display("cycle %h done", r.a);
   endtask
   task automatic wait_refresh();
      int k = 0;
      while (refresh_address_select !== 1'h1 && k < 1000) begin
         @(negedge core_clk);
         k++;
      end
      for (int i = 0; i < 40 && row_strobe_n; i++) @(negedge core_clk);
      check("refresh", 24'({row_strobe_n, bank0_row_strobe, bank1_row_strobe, col_strobe_n,
         refresh_address_select}), 24'h000003);
   endtask
   initial begin
      core_clk = 1'h0;
      forever #10 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         print_verdict();
      end
   end
   initial begin
      resetn = 1'h0;
      ale = 1'h0;
      rd_n = 1'h1;
      wr_n = 1'h1;
      cpu_addr = 20'h00000;
      window_first_block = 3'h1;
      repeat (5) @(negedge core_clk);
      check_idle();
      @(negedge core_clk);
      resetn = 1'h1;
      foreach (rows[i]) do_row(rows[i]);
      wait_refresh();
      r0 = dram_addr;
      repeat (100) @(negedge core_clk);
      wait_refresh();
      check("refresh row", 24'(dram_addr), 24'(r0 + 8'h01));
      $display("refresh test done");
      wait_refresh();
      // a cycle requested mid-refresh is held back, not dropped
      do_row(rows[1]);
      wait_refresh();
      resetn = 1'h0;
      @(negedge core_clk);
      check_idle();
      resetn = 1'h1;
      do_row(rows[3]);
      $display("reset test done");
      print_verdict();
   end
endmodule // expansion_dram_refresh_control_tb
`default_nettype wire
